//--- hdl/scan_map.svh
// Constants of the LED scan and keyboard controller: offsets, fields, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH
// Clock and scan rate
`define CLK_HZ      25000000
`define SCAN_HZ     6000
`define SCAN_DIV    (`CLK_HZ / `SCAN_HZ)
// Scan sequence
`define SCAN_STATES 13
`define DIGIT_COLS  11
`define ANN_COLS    2
`define LAST_COL    4'hC
`define PRE_EOS_COL 4'hB
`define BLANK_HI    5'h10
`define BLANK_LO    3'h7
// Register byte offsets
`define OFF_DISP    12'h000
`define OFF_KEY     12'h004
// Display write register fields
`define DW_ADDR_MSB 11
`define DW_ADDR_LSB 8
// Key status register fields
`define KS_ROW      4
`define KS_IRQ      5
`define KS_RANGE    6
`define KS_DOWN     7
`define KS_BAND     8
// Reset values and strobe length
`define RST_DISP    12'h000
`define STB_CYCLES  2
`endif

//--- hdl/scan_pkg.sv
// Types shared by the scan controller and its testbench.
// Assumes scan_map.svh supplies the numeric constants.
package scan_pkg;
  typedef logic [3:0] col_t;
  typedef logic [3:0] mem_addr_t;
  typedef logic [3:0] nibble_t;
  typedef enum logic [1:0]
  {
    REG_DISP = 2'b00,
    REG_KEY  = 2'b01,
    REG_NONE = 2'b10
  } reg_sel_t;
endpackage

//--- hdl/pin_sync_if.sv
// Interface carrying raw pin levels into the synchroniser and clean levels out.
// Assumes one clock domain on the consuming side.
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] q;
  modport sync (input raw, output q);
  modport user (output raw, input q);
endinterface

//--- hdl/pin_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes sys_clk and a synchronous active-low reset; reset values given.
`timescale 1ns/1ps
module pin_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic  sys_clk, // System clock
  input  wire logic  rstn,    // Synchronous reset, active low
  pin_sync_if.sync   p        // Raw in, clean out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage is read only by the second
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      meta_ff <= RST;
      q_ff    <= RST;
    end
    else
    begin
      meta_ff <= p.raw;
      q_ff    <= meta_ff;
    end
  end

  assign p.q = q_ff;
endmodule

//--- hdl/led_scan_keyboard_controller.sv
// LED display multiplexer and keyboard scanner behind an APB slave.
// Assumes APB on sys_clk (25 MHz); key, switch and display reset pins are asynchronous.
`timescale 1ns/1ps
`include "scan_map.svh"
module led_scan_keyboard_controller #(
  parameter int SCAN_DIV = `SCAN_DIV
) (
  input  wire logic      sys_clk,            // 25 MHz clock
  input  wire logic      rstn,               // Synchronous reset, active low
  input  wire logic      psel,               // APB select
  input  wire logic      penable,            // APB enable
  input  wire logic      pwrite,             // APB direction
  input  wire logic [11:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic [31:0]    prdata,             // APB read data
  output logic           pready,             // APB ready
  output logic           pslverr,            // APB error, unmapped address
  input  wire logic      display_reset_n,    // Blanks display while low
  input  wire logic      key_top_n,          // Top row return, low if pressed
  input  wire logic      key_bot_n,          // Bottom row return, low if pressed
  input  wire logic      range_switch,       // Range switch position
  input  wire logic      band_direct,        // High in direct low band mode
  output logic [12:0]    column_sel_n,       // Column drives, active low
  output logic [7:0]     segment_n,          // Segments dp,g,f,e,d,c,b,a low on
  output logic           key_interrupt_request_n, // Key interrupt, active low
  output logic           key_down,           // Key held status
  output scan_pkg::col_t scan_column         // Column counter state, registered one cycle late
);
  import scan_pkg::*;

  localparam int DIVW = 13;
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SCAN_DIV - 1);
  localparam logic [DIVW-1:0] DIV_MID  = DIVW'(SCAN_DIV / 2);

  // Synchronised pins
  logic dres_q, top_q, bot_q, range_q, band_q;
  pin_sync_if #(.W(5)) pins ();
  assign pins.raw = {display_reset_n, key_top_n, key_bot_n, range_switch, band_direct};
  assign {dres_q, top_q, bot_q, range_q, band_q} = pins.q;

  // Pins pass two flops before use
  pin_sync #(
    .W   (5),
    .RST (5'h0C)    // Display held blank, row returns idle high
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .p       (pins.sync)
  );

  // Scan divider and column counter
  logic [DIVW-1:0] div_ff;
  col_t            col_ff;
  logic            tick, phase, eos;
  assign tick  = (div_ff == DIV_LAST);
  assign phase = (div_ff == DIV_MID);
  assign eos   = tick && (col_ff == `PRE_EOS_COL);

  // Free running scan clock divider
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      div_ff <= '0;
    else if (tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + DIVW'(1);
  end

  // Thirteen state column counter
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      col_ff <= 4'h0;
    else if (tick && col_ff == `LAST_COL)
      col_ff <= 4'h0;
    else if (tick)
      col_ff <= col_ff + 4'h1;
  end

  // Column decoders, blanked by out of range codes
  logic [4:0]  code_hi;
  logic [2:0]  code_lo;
  logic [12:0] nxt_sel;
  assign code_hi = dres_q ? {1'b0, col_ff} : `BLANK_HI;
  assign code_lo = (dres_q && col_ff[3]) ? col_ff[2:0] : `BLANK_LO;
  assign nxt_sel[7:0]  = 8'(9'h001 << code_hi); // Codes 8 and up select nothing here
  assign nxt_sel[12:8] = 5'(8'h01 << code_lo);  // Code 7 selects nothing here

  // Digits on 0 to 10, annunciators on 11 and 12
  logic [12:0] column_sel_n_ff;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      column_sel_n_ff <= 13'h1FFF;
    else
      column_sel_n_ff <= ~nxt_sel;
  end
  assign column_sel_n = column_sel_n_ff;

  // APB access and internal strobes
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        access;
  logic        done;
  reg_sel_t    rsel;
  assign access = psel && penable;
  assign done   = access && pready_ff;

  // Address decode
  always_comb
  begin
    if (paddr == `OFF_DISP)
      rsel = REG_DISP;
    else if (paddr == `OFF_KEY)
      rsel = REG_KEY;
    else
      rsel = REG_NONE;
  end

  // Ready one cycle into the access phase
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pready_ff <= 1'b0;
    else
      pready_ff <= access && !pready_ff;
  end

  // Display write register and strobe
  logic [11:0] disp_ff;
  logic [1:0]  stb_ff;
  logic        wr_pulse;
  mem_addr_t   wr_addr;
  logic [7:0]  wr_data;
  assign wr_addr  = disp_ff[`DW_ADDR_MSB:`DW_ADDR_LSB];
  assign wr_data  = disp_ff[7:0];
  assign wr_pulse = stb_ff[0] && !stb_ff[1];

  // Latch location and data on the same edge that raises the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      disp_ff <= `RST_DISP;
    else if (done && pwrite && rsel == REG_DISP)
      disp_ff <= pwdata[11:0];
  end

  // Strobe stays high for STB_CYCLES cycles
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      stb_ff <= 2'b00;
    else if (done && pwrite && rsel == REG_DISP)
      stb_ff <= 2'b01;
    else if (stb_ff == 2'b01)
      stb_ff <= 2'b11;
    else
      stb_ff <= 2'b00;
  end

  // Refresh memory, two nibble halves
  nibble_t   mem_lo_ff [16];
  nibble_t   mem_hi_ff [16];
  mem_addr_t mem_addr;
  assign mem_addr = stb_ff[0] ? wr_addr : col_ff;

  // Write on the strobe's rising edge only
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem_lo_ff[i] <= 4'h0;
        mem_hi_ff[i] <= 4'h0;
      end
    end
    else if (wr_pulse)
    begin
      mem_lo_ff[mem_addr] <= wr_data[3:0];
      mem_hi_ff[mem_addr] <= wr_data[7:4];
    end
  end

  // Segment drive, a stored one pulls the segment low
  logic [7:0] segment_n_ff;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      segment_n_ff <= 8'hFF;
    else if (!dres_q)
      segment_n_ff <= 8'hFF;
    else
      segment_n_ff <= ~{mem_hi_ff[mem_addr], mem_lo_ff[mem_addr]};
  end
  assign segment_n = segment_n_ff;

  // Key detection at mid column, while the column is driven
  logic key_pulse_n;
  logic capture;
  assign key_pulse_n = !(dres_q && (!top_q || !bot_q));
  assign capture     = !key_pulse_n && phase;

  // Key address and row latch
  col_t key_col_ff;
  logic key_row_ff, key_down_ff;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      key_col_ff <= 4'h0;
      key_row_ff <= 1'b0;
    end
    else if (capture && !key_down_ff)
    begin
      key_col_ff <= col_ff;
      key_row_ff <= top_q;
    end
  end

  // Key seen flag, capture wins over end of scan
  logic key_seen_ff;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      key_seen_ff <= 1'b0;
    else if (capture)
      key_seen_ff <= 1'b1;
    else if (eos)
      key_seen_ff <= 1'b0;
  end

  // Key down loaded at end of scan
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      key_down_ff <= 1'b0;
    else if (eos)
      key_down_ff <= key_seen_ff || capture;
  end
  assign key_down = key_down_ff;

  // Interrupt flop, stored inverted; set wins over read clear
  logic irq_set, kbrd_strobe_n, irq_n_ff;
  assign irq_set       = eos && !key_down_ff && (key_seen_ff || capture);
  assign kbrd_strobe_n = !(done && !pwrite && rsel == REG_KEY);
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_n_ff <= 1'b1;
    else if (irq_set)
      irq_n_ff <= 1'b0;
    else if (!kbrd_strobe_n)
      irq_n_ff <= 1'b1;
  end
  assign key_interrupt_request_n = irq_n_ff;

  // Read data mux, unmapped answers with an error
  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (rsel == REG_DISP)
      nxt_rdata[11:0] = disp_ff;
    else if (rsel == REG_KEY)
    begin
      nxt_rdata[3:0]       = key_col_ff;
      nxt_rdata[`KS_ROW]   = key_row_ff;
      nxt_rdata[`KS_IRQ]   = !irq_n_ff;
      nxt_rdata[`KS_RANGE] = range_q;
      nxt_rdata[`KS_DOWN]  = key_down_ff;
      nxt_rdata[`KS_BAND]  = band_q;
    end
  end

  // Read data and error registered with ready
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (access && !pready_ff)
    begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_rdata;
      pslverr_ff <= (rsel == REG_NONE);
    end
    else
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // Column state export
  col_t scan_col_ff;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      scan_col_ff <= 4'h0;
    else
      scan_col_ff <= col_ff;
  end
  assign scan_column = scan_col_ff;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_col_range: assert property (col_ff <= `LAST_COL)
    else $error("column counter out of range");
  a_col_wrap: assert property (tick && col_ff == `LAST_COL |=> col_ff == 4'h0)
    else $error("counter did not wrap after state 12");
  a_col_hold: assert property (!tick |=> $stable(col_ff))
    else $error("column moved without a scan tick");
  a_blank_rst: assert property (!dres_q |=> column_sel_n_ff == 13'h1FFF)
    else $error("column driven during display reset");
  a_one_col: assert property (dres_q |=> $onehot(~column_sel_n_ff))
    else $error("not exactly one column selected");
  a_pulse_once: assert property (wr_pulse |=> !wr_pulse ##1 !wr_pulse)
    else $error("write pulse longer than one cycle");
  a_addr_mux: assert property (dres_q && !stb_ff[0] |=>
    segment_n_ff == ~{mem_hi_ff[$past(col_ff)], mem_lo_ff[$past(col_ff)]})
    else $error("segments not read from the scanned location");
  a_mem_store: assert property (wr_pulse |=>
    {mem_hi_ff[wr_addr], mem_lo_ff[wr_addr]} == $past(wr_data))
    else $error("segment byte not stored");
  a_latch_block: assert property (key_down_ff |=> $stable(key_col_ff))
    else $error("key latch changed while key down");
  a_eos_load: assert property (eos |=> key_down_ff == $past(key_seen_ff))
    else $error("key down not loaded at end of scan");
  a_irq_set: assert property ($rose(key_down_ff) |-> !key_interrupt_request_n)
    else $error("interrupt not raised on key down");
  a_irq_clear: assert property (!kbrd_strobe_n && !irq_set |=> key_interrupt_request_n)
    else $error("keyboard read did not clear interrupt");

  c_capture: cover property (capture && !key_down_ff);
  c_irq: cover property ($fell(key_interrupt_request_n));
  c_write: cover property (wr_pulse);
  c_kbrd: cover property (!kbrd_strobe_n && !irq_n_ff);
endmodule

//--- tb/keypad_model.sv
// Keypad model: one held key closes its row return while its column is driven.
// Assumes active-low column drives; open row returns are pulled up to high.
`timescale 1ns/1ps
module keypad_model (
  input  wire logic [12:0] column_sel_n, // Column drives from the scanner
  input  wire logic        key_on,       // A key is held
  input  wire logic [3:0]  key_col,      // Column of the held key
  input  wire logic        key_row,      // 0 top row, 1 bottom row
  output logic             key_top_n,    // Top row return
  output logic             key_bot_n     // Bottom row return
);
  logic hit;

  // Contact closes only while the key's own column is driven low
  assign hit       = key_on && (column_sel_n[key_col] == 1'b0);
  assign key_top_n = !(hit && !key_row);
  assign key_bot_n = !(hit && key_row);
endmodule

//--- tb/tb.sv
// Testbench: APB master tasks, keypad model, checks of scan, memory and keys.
// Assumes the design at a short scan divider and a 25 MHz clock.
`timescale 1ns/1ps
module tb;
  logic           sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic           display_reset_n, key_top_n, key_bot_n, range_switch, band_direct;
  logic [12:0]    column_sel_n;
  logic [7:0]     segment_n;
  logic           key_interrupt_request_n, key_down, key_on, key_row;
  logic [3:0]     key_col;
  scan_pkg::col_t scan_column;
  int             failures, n_checks, cycles;

  led_scan_keyboard_controller #(.SCAN_DIV(16)) u_led_scan_keyboard_controller (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_reset_n(display_reset_n), .key_top_n(key_top_n), .key_bot_n(key_bot_n),
    .range_switch(range_switch), .band_direct(band_direct), .column_sel_n(column_sel_n),
    .segment_n(segment_n), .key_interrupt_request_n(key_interrupt_request_n),
    .key_down(key_down), .scan_column(scan_column));

  keypad_model u_keypad_model (
    .column_sel_n(column_sel_n), .key_on(key_on), .key_col(key_col), .key_row(key_row),
    .key_top_n(key_top_n), .key_bot_n(key_bot_n));

  // Clock, 40 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Cycle ceiling against hangs
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      $display("unexpected at %0t: run too long", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
      begin
        failures++;
        $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
  endtask

  // One APB transfer; holds the request until pready is seen or 50 cycles pass
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk(pready, 1'b1, "pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic probe(input int w);
    if (w < 13)
      return column_sel_n[w];
    if (w == 13)
      return key_interrupt_request_n;
    return key_down;
  endfunction

  // Waits for a column select, the interrupt or key_down to reach a level
  task automatic wait_until(input int w, input logic lvl, input string what);
    int n;
    n = 0;
    while (probe(w) !== lvl && n < 1000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(probe(w), lvl, what);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d checks so far", name, n_checks);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    cycles = 0;
    failures = 0;
    n_checks = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    display_reset_n = 1'b1;
    range_switch = 1'b1;
    band_direct = 1'b0;
    key_on = 1'b0;
    key_col = 4'h0;
    key_row = 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk(column_sel_n, 13'h1FFF, "columns at reset");
    chk(segment_n, 8'hFF, "segments at reset");
    chk(key_interrupt_request_n, 1'b1, "irq at reset");
    chk(key_down, 1'b0, "key down at reset");
    end_test("reset");
    // Each of locations 0 to 12 shows on its own column, annunciators included
    for (int c = 0; c < 13; c++)
    begin
      apb(1'b1, 12'h000, {20'h0, c[3:0], 8'h5A ^ c[7:0]});
      wait_until((c + 1) % 13, 1'b0, "next column");
      wait_until(c, 1'b0, "column select");
      @(posedge sys_clk);
      chk(column_sel_n, 13'(~(13'h1 << c)), "one column");
      chk(scan_column, c, "scan column");
      chk(segment_n, 8'(~(8'h5A ^ c[7:0])), "segments");
    end
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h00000C56, "readback");
    chk(err, 1'b0, "readback error");
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    end_test("display");
    display_reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(column_sel_n, 13'h1FFF, "blank columns");
    chk(segment_n, 8'hFF, "blank segments");
    display_reset_n <= 1'b1;
    end_test("blank");
    // Bottom key in column 5, then moved while held: latch must stay
    key_col <= 4'h5;
    key_row <= 1'b1;
    key_on <= 1'b1;
    wait_until(13, 1'b0, "irq raised");
    chk(key_down, 1'b1, "key down");
    key_col <= 4'h2;
    wait_until(2, 1'b0, "moved key column");
    wait_until(3, 1'b0, "past moved key");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h000000F5, "key status");
    chk(err, 1'b0, "key status error");
    repeat (3) @(posedge sys_clk);
    chk(key_interrupt_request_n, 1'b1, "irq cleared");
    key_on <= 1'b0;
    wait_until(14, 1'b0, "key released");
    // Top key on the last column with other switch levels
    range_switch <= 1'b0;
    band_direct <= 1'b1;
    key_col <= 4'hC;
    key_row <= 1'b0;
    key_on <= 1'b1;
    wait_until(13, 1'b0, "irq again");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h000001AC, "key status top");
    key_on <= 1'b0;
    wait_until(14, 1'b0, "second release");
    end_test("keys");
    report_and_stop();
  end
endmodule
